// *** hdl/rtc_cfg_params.svh ***
/*
  Constants of the clock configuration bank: register indexes, reset
  values, field positions and lock windows.
  Assumes inclusion by bare name from the design files and the checker.
*/
`ifndef RTC_CFG_PARAMS_SVH
`define RTC_CFG_PARAMS_SVH

// ------------------------------------------------------------
// register indexes (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_ACTIVATE 8'h30
`define IDX_STD_BASE_HIGH 8'h60
`define IDX_STD_BASE_LOW 8'h61
`define IDX_EXT_BASE_HIGH 8'h62
`define IDX_EXT_BASE_LOW 8'h63
`define IDX_IRQ_NUMBER 8'h70
`define IDX_IRQ_TYPE 8'h71
`define IDX_DMA_FIRST 8'h74
`define IDX_DMA_SECOND 8'h75
`define IDX_RAM_LOCK 8'hf0
`define IDX_DAY_ALARM 8'hf1
`define IDX_MONTH_ALARM 8'hf2
`define IDX_CENTURY 8'hf3

// ------------------------------------------------------------
// reset values and fixed answers
// ------------------------------------------------------------
`define RST_ACTIVATE 8'h00
`define RST_STD_BASE_HIGH 8'h00
`define RST_STD_BASE_LOW 8'h70
`define RST_EXT_BASE_HIGH 8'h00
`define RST_EXT_BASE_LOW 8'h72
`define RST_IRQ_NUMBER 8'h08
`define RST_IRQ_TYPE 8'h00
`define RST_LOCK 8'h00
`define RST_OFFSET 7'h00
`define DMA_NONE 8'h04
`define BLOCKED_READ 8'hff

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define ACTIVATE_BIT 0
`define IRQ_TYPE_RW_MASK 8'h02
`define BASE_LOW_MASK 8'hfe
`define LOCK_MASK 8'hf8
`define LOCK_STD_WIN 7
`define LOCK_ALL_WR 6
`define LOCK_EXT_LOW_WR 5
`define LOCK_EXT_LOW_RD 4
`define LOCK_EXT_ALL 3
`define STD_WIN_FIRST 8'h38
`define STD_WIN_LAST 8'h3f
`define EXT_LOW_LAST 8'h1f

`endif

// *** hdl/rtc_cfg_pkg.sv ***
/*
  Types shared by the clock configuration bank and its RAM gate.
  Assumes the constants header is on the include path.
*/
package rtc_cfg_pkg;

  typedef struct packed {
    logic rd;
    logic wr;
    logic ext;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rt_req_t;

  typedef struct packed {
    logic re;
    logic we;
    logic ext;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ram_cmd_t;

  typedef struct packed {
    logic active;
    logic [15:0] std_base;
    logic [15:0] ext_base;
    logic [7:0] irq_number;
    logic [7:0] irq_type;
  } cfg_t;

  typedef struct packed {
    logic [6:0] day;
    logic [6:0] month;
    logic [6:0] century;
  } offsets_t;

endpackage

// *** hdl/rtc_ram_gate.sv ***
/*
  Gate between host runtime accesses and the battery-backed RAM:
  applies the activate bit and the lock bits, one cycle to the RAM
  command, one more to read data.
  Assumes the RAM returns read data combinationally from ram_cmd.
*/
`timescale 1ns/1ps
`include "rtc_cfg_params.svh"

module rtc_ram_gate
  import rtc_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire rt_req_t req,
  input wire logic active,
  input wire logic [7:0] lock,
  input wire logic [7:0] ram_rdata,
  output ram_cmd_t ram_cmd,
  output logic [7:0] rdata,
  output logic rvalid
);

  // ------------------------------------------------------------
  // region and block decode
  // ------------------------------------------------------------
  wire std_win = !req.ext && req.addr >= `STD_WIN_FIRST &&
                 req.addr <= `STD_WIN_LAST;
  wire ext_low = req.ext && req.addr <= `EXT_LOW_LAST;
  wire wr_block = !active // R1
                  || lock[`LOCK_ALL_WR] // R10
                  || (ext_low && lock[`LOCK_EXT_LOW_WR]) // R11
                  || (req.ext && lock[`LOCK_EXT_ALL]) // R13
                  || (std_win && lock[`LOCK_STD_WIN]); // R9
  wire rd_block = !active // R1
                  || (ext_low && lock[`LOCK_EXT_LOW_RD]) // R12
                  || (req.ext && lock[`LOCK_EXT_ALL]) // R13
                  || (std_win && lock[`LOCK_STD_WIN]); // R9

  logic rd_block_q;
  logic rd_pend;

  // ------------------------------------------------------------
  // pipeline
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ram_cmd <= '0;
      rd_block_q <= 1'b0;
      rd_pend <= 1'b0;
    end else begin
      ram_cmd.re <= req.rd && !rd_block;
      ram_cmd.we <= req.wr && !wr_block;
      ram_cmd.ext <= req.ext;
      ram_cmd.addr <= req.addr;
      ram_cmd.wdata <= req.wdata;
      rd_block_q <= rd_block;
      rd_pend <= req.rd;
    end
  end

  // blocked reads answer ff without touching the RAM
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_pend;
      rdata <= rd_block_q ? `BLOCKED_READ : ram_rdata;
    end
  end

endmodule

// *** hdl/rtc_config_and_ram_lock.sv ***
/*
  Configuration bank of the real-time clock logical device: standard
  registers on the main supply reset, lock and alarm offset registers
  on the standby reset, Avalon-MM slave with waitrequest, and the
  gate that guards host accesses to the battery-backed RAM.
  Assumes standby_lock_select and unlock_request come from the serial
  lock control logic on the same clock, and that clk runs while either
  reset is asserted.
*/
// Overview of operation
// (R1) activate bit 0 clear makes every runtime access of the device blocked.
// (R2) standard base high resets 00, low resets 70, low bit reads zero.
// (R3) extended RAM base high resets 00, low resets 72, low bit zero.
// (R4) interrupt number and wake enable register is read/write, resets 08.
// (R5) interrupt type: only bit 1 writable, rest read-only, resets 00.
// (R6) both DMA report registers read-only, always return 04.
// (R7) lock bits write-one-to-set; cleared by reset chosen by select bit.
// (R8) unlock request clears every lock bit; a lock write on the same edge still sets its bits.
// (R9) bit 7 blocks standard RAM 38-3f: writes ignored, reads give ff.
// (R10) bit 6 ignores all writes to standard and extended RAM.
// (R11) bit 5 ignores writes to extended RAM bytes 00-1f.
// (R12) bit 4 makes reads of extended RAM bytes 00-1f return ff.
// (R13) bit 3 blocks all extended RAM writes; its reads return ff.
// (R14) day alarm offset at f1: resets 00, top bit reserved.
// (R15) month alarm offset at f2: 7-bit field, resets 00.
// (R16) century offset at f3: 7-bit field, bit 7 reserved.
// (R17) standard registers on main reset; lock and offsets on standby.
// (R18) reserved lock and offset bits read zero, ignore writes.
`timescale 1ns/1ps
`include "rtc_cfg_params.svh"

module rtc_config_and_ram_lock
  import rtc_cfg_pkg::*;
#(
  parameter int ADDR_WIDTH = 10
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sb_rstn,
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic standby_lock_select,
  input wire logic unlock_request,
  input wire rt_req_t rt_req,
  input wire logic [7:0] ram_rdata,
  output ram_cmd_t ram_cmd,
  output logic [7:0] rt_rdata,
  output logic rt_rvalid,
  output cfg_t cfg,
  output offsets_t offsets,
  output logic [7:0] ram_lock
);

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  // main supply domain
  logic [7:0] logical_device_activate;
  logic [7:0] standard_base_high;
  logic [7:0] standard_base_low;
  logic [7:0] extended_ram_base_high;
  logic [7:0] extended_ram_base_low;
  logic [7:0] interrupt_number_wake;
  logic [7:0] interrupt_type;
  logic main_alive;

  // standby domain
  logic [6:0] day_alarm_offset;
  logic [6:0] month_alarm_offset;
  logic [6:0] century_offset;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // a request is taken once, on the edge where waitrequest is high;
  // the next edge shows waitrequest low and ends it
  wire take = (read || write) && waitrequest;
  // writes commit on the edge where the master sees waitrequest low
  wire wr_take = write && !waitrequest && byteenable[0];
  wire [7:0] idx = address[9:2];
  wire [7:0] wbyte = writedata[7:0];

  wire hit_activate = idx == `IDX_ACTIVATE;
  wire hit_std_high = idx == `IDX_STD_BASE_HIGH;
  wire hit_std_low = idx == `IDX_STD_BASE_LOW;
  wire hit_ext_high = idx == `IDX_EXT_BASE_HIGH;
  wire hit_ext_low = idx == `IDX_EXT_BASE_LOW;
  wire hit_irq_num = idx == `IDX_IRQ_NUMBER;
  wire hit_irq_type = idx == `IDX_IRQ_TYPE;
  wire hit_dma_first = idx == `IDX_DMA_FIRST;
  wire hit_dma_second = idx == `IDX_DMA_SECOND;
  wire hit_lock = idx == `IDX_RAM_LOCK;
  wire hit_day = idx == `IDX_DAY_ALARM;
  wire hit_month = idx == `IDX_MONTH_ALARM;
  wire hit_century = idx == `IDX_CENTURY;

  // ------------------------------------------------------------
  // lock next value
  // ------------------------------------------------------------
  // main reset seen while the select bit picks the main supply:
  // cleared synchronously, since the selection is not a constant
  // and must not steer an asynchronous reset
  wire main_clear = !main_alive && !standby_lock_select; // R7
  wire lock_clear = main_clear || unlock_request; // R8
  wire [7:0] lock_set = wr_take && hit_lock ? wbyte : 8'h00;
  // set wins over a clear in the same cycle
  wire [7:0] next_ram_lock =
    ((ram_lock & ~{8{lock_clear}}) | lock_set) & `LOCK_MASK; // R7 R18

  // ------------------------------------------------------------
  // read multiplexer
  // ------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    if (hit_activate) begin
      rd_byte = logical_device_activate;
    end else if (hit_std_high) begin
      rd_byte = standard_base_high;
    end else if (hit_std_low) begin
      rd_byte = standard_base_low & `BASE_LOW_MASK; // R2
    end else if (hit_ext_high) begin
      rd_byte = extended_ram_base_high;
    end else if (hit_ext_low) begin
      rd_byte = extended_ram_base_low & `BASE_LOW_MASK; // R3
    end else if (hit_irq_num) begin
      rd_byte = interrupt_number_wake;
    end else if (hit_irq_type) begin
      rd_byte = interrupt_type;
    end else if (hit_dma_first || hit_dma_second) begin
      rd_byte = `DMA_NONE; // R6
    end else if (hit_lock) begin
      rd_byte = ram_lock;
    end else if (hit_day) begin
      rd_byte = {1'b0, day_alarm_offset}; // R14 R18
    end else if (hit_month) begin
      rd_byte = {1'b0, month_alarm_offset}; // R15 R18
    end else if (hit_century) begin
      rd_byte = {1'b0, century_offset}; // R16 R18
    end else begin
      // unmapped indexes read zero and ignore writes
      rd_byte = 8'h00;
    end
  end

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !take;
    end
  end

  // read data is held until the next taken read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (take && read) begin
      readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ------------------------------------------------------------
  // main supply registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      main_alive <= 1'b0;
    end else begin
      main_alive <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      logical_device_activate <= `RST_ACTIVATE; // R17
    end else if (wr_take && hit_activate) begin
      logical_device_activate <= wbyte;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standard_base_high <= `RST_STD_BASE_HIGH; // R2
    end else if (wr_take && hit_std_high) begin
      standard_base_high <= wbyte;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standard_base_low <= `RST_STD_BASE_LOW; // R2
    end else if (wr_take && hit_std_low) begin
      standard_base_low <= wbyte & `BASE_LOW_MASK; // R2
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extended_ram_base_high <= `RST_EXT_BASE_HIGH; // R3
    end else if (wr_take && hit_ext_high) begin
      extended_ram_base_high <= wbyte;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extended_ram_base_low <= `RST_EXT_BASE_LOW; // R3
    end else if (wr_take && hit_ext_low) begin
      extended_ram_base_low <= wbyte & `BASE_LOW_MASK; // R3
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_number_wake <= `RST_IRQ_NUMBER; // R4
    end else if (wr_take && hit_irq_num) begin
      interrupt_number_wake <= wbyte; // R4
    end
  end

  // only the writable bit can ever leave its reset value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_type <= `RST_IRQ_TYPE; // R5
    end else if (wr_take && hit_irq_type) begin
      interrupt_type <= (interrupt_type & ~`IRQ_TYPE_RW_MASK) |
                        (wbyte & `IRQ_TYPE_RW_MASK); // R5
    end
  end

  // ------------------------------------------------------------
  // standby registers
  // ------------------------------------------------------------
  // untouched by rstn; the offsets survive a main supply reset, ram_lock only while standby_lock_select is high
  always_ff @(posedge clk or negedge sb_rstn) begin
    if (!sb_rstn) begin
      ram_lock <= `RST_LOCK; // R17
    end else begin
      ram_lock <= next_ram_lock; // R7
    end
  end

  always_ff @(posedge clk or negedge sb_rstn) begin
    if (!sb_rstn) begin
      day_alarm_offset <= `RST_OFFSET; // R14
    end else if (wr_take && hit_day) begin
      day_alarm_offset <= wbyte[6:0]; // R14
    end
  end

  always_ff @(posedge clk or negedge sb_rstn) begin
    if (!sb_rstn) begin
      month_alarm_offset <= `RST_OFFSET; // R15
    end else if (wr_take && hit_month) begin
      month_alarm_offset <= wbyte[6:0]; // R15
    end
  end

  always_ff @(posedge clk or negedge sb_rstn) begin
    if (!sb_rstn) begin
      century_offset <= `RST_OFFSET; // R16
    end else if (wr_take && hit_century) begin
      century_offset <= wbyte[6:0]; // R16
    end
  end

  // ------------------------------------------------------------
  // configuration outputs
  // ------------------------------------------------------------
  // plain wiring of the flops above; the runtime decoder relocates
  // the alarm and century registers with the offsets
  assign cfg.active = logical_device_activate[`ACTIVATE_BIT];
  assign cfg.std_base = {standard_base_high, standard_base_low};
  assign cfg.ext_base = {extended_ram_base_high, extended_ram_base_low};
  assign cfg.irq_number = interrupt_number_wake;
  assign cfg.irq_type = interrupt_type;
  assign offsets.day = day_alarm_offset;
  assign offsets.month = month_alarm_offset;
  assign offsets.century = century_offset;

  // ------------------------------------------------------------
  // runtime RAM gate
  // ------------------------------------------------------------
  // limitation: a lock set by the bus applies from the cycle after
  // the write edge; an access taken on that very edge still passes
  rtc_ram_gate u_gate (
    .clk(clk),
    .rstn(rstn),
    .req(rt_req),
    .active(logical_device_activate[`ACTIVATE_BIT]), // R1
    .lock(ram_lock), // R9 R10 R11 R12 R13
    .ram_rdata(ram_rdata),
    .ram_cmd(ram_cmd),
    .rdata(rt_rdata),
    .rvalid(rt_rvalid)
  );

endmodule

// *** tb/rtc_cfg_chk.sv ***
/*
  Concurrent checks of the clock configuration bank, bound to its ports.
  Assumes one clock and the two active-low resets of the top module.
*/
`timescale 1ns/1ps
`include "rtc_cfg_params.svh"
module rtc_cfg_chk
  import rtc_cfg_pkg::*;
#(
  parameter int ADDR_WIDTH = 10
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sb_rstn,
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic standby_lock_select,
  input wire logic unlock_request,
  input wire rt_req_t rt_req,
  input wire logic [7:0] ram_rdata,
  input wire ram_cmd_t ram_cmd,
  input wire logic [7:0] rt_rdata,
  input wire logic rt_rvalid,
  input wire cfg_t cfg,
  input wire offsets_t offsets,
  input wire logic [7:0] ram_lock
);
  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  wire logic [7:0] idx = 8'(address[ADDR_WIDTH-1:2]);
  wire logic taken = (read | write) & waitrequest;
  wire logic lk_wr = write & !waitrequest & byteenable[0] &
    (idx == `IDX_RAM_LOCK);
  wire logic acc = rt_req.rd | rt_req.wr;
  wire logic low = rt_req.addr <= `EXT_LOW_LAST;
  wire logic win = rt_req.addr >= `STD_WIN_FIRST &&
    rt_req.addr <= `STD_WIN_LAST;
  wire logic [7:0] set_bits = writedata[7:0] & `LOCK_MASK;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !sb_rstn);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  AST_INACTIVE: assert property (acc && !cfg.active |=>
    !ram_cmd.re && !ram_cmd.we) else $error("inactive access passed");
  AST_PASS_WR: assert property (rt_req.wr && cfg.active && ram_lock == 0
    |=> ram_cmd.we && ram_cmd.addr == $past(rt_req.addr) &&
    ram_cmd.wdata == $past(rt_req.wdata)) else $error("open write lost");
  AST_BASE_LSB: assert property (!cfg.std_base[0] && !cfg.ext_base[0])
    else $error("base low bit set");
  AST_DMA: assert property (taken && read && (idx == `IDX_DMA_FIRST ||
    idx == `IDX_DMA_SECOND) |=> readdata[7:0] == `DMA_NONE)
    else $error("dma report wrong");
  AST_LOCK_SET: assert property (lk_wr |=>
    (ram_lock & $past(set_bits)) == $past(set_bits))
    else $error("lock bit not set");
  AST_LOCK_STICKY: assert property (!unlock_request && $past(rstn) |=>
    (ram_lock & $past(ram_lock)) == $past(ram_lock))
    else $error("lock bit dropped");
  AST_UNLOCK: assert property (unlock_request && !lk_wr |=>
    ram_lock == 8'h00) else $error("unlock ignored");
  AST_STD_WIN: assert property (acc && !rt_req.ext && win && ram_lock[7]
    |=> !ram_cmd.re && !ram_cmd.we) else $error("window not blocked");
  AST_ALL_WR: assert property (rt_req.wr && ram_lock[6] |=> !ram_cmd.we)
    else $error("write not blocked");
  AST_EXT_LOW_WR: assert property (rt_req.wr && rt_req.ext && low &&
    ram_lock[5] |=> !ram_cmd.we) else $error("ext low write passed");
  AST_EXT_LOW_RD: assert property (rt_req.rd && rt_req.ext && low &&
    ram_lock[4] |-> ##2 rt_rvalid && rt_rdata == `BLOCKED_READ)
    else $error("ext low read not ff");
  AST_EXT_ALL: assert property (acc && rt_req.ext && ram_lock[3] |=>
    !ram_cmd.re && !ram_cmd.we) else $error("ext ram not blocked");
  AST_RSVD: assert property (ram_lock[2:0] == 3'h0)
    else $error("reserved lock bit set");
  AST_OFFS_KEEP: assert property (@(posedge clk) disable iff (!sb_rstn)
    !rstn |=> $stable(offsets)) else $error("offsets lost on main reset");

  cover property (lk_wr);
  cover property (unlock_request && ram_lock != 8'h00);
  cover property (rt_req.rd && rt_req.ext && ram_lock[4]);
endmodule

bind rtc_config_and_ram_lock rtc_cfg_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk (
  .clk(clk), .rstn(rstn), .sb_rstn(sb_rstn), .address(address),
  .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .standby_lock_select(standby_lock_select),
  .unlock_request(unlock_request), .rt_req(rt_req), .ram_rdata(ram_rdata),
  .ram_cmd(ram_cmd), .rt_rdata(rt_rdata), .rt_rvalid(rt_rvalid),
  .cfg(cfg), .offsets(offsets), .ram_lock(ram_lock)
);

// *** tb/tb.sv ***
/*
  Self-checking bench of the clock configuration bank: register table,
  lock gating of runtime RAM accesses, resets.
  Assumes the RAM answers combinationally; modelled as address xor 5a.
*/
`timescale 1ns/1ps
module tb
  import rtc_cfg_pkg::*;
;
  typedef struct packed {logic [7:0] idx, rst, wd, exp;} row_t;
  logic clk = 0, rstn = 0, sb_rstn = 0, read = 0, write = 0;
  logic [9:0] address = '0;
  logic [31:0] writedata = '0;
  logic [3:0] byteenable = '0;
  logic standby_lock_select = 0, unlock_request = 0;
  rt_req_t rt_req = '0;
  logic [31:0] readdata;
  logic waitrequest, rt_rvalid;
  ram_cmd_t ram_cmd;
  logic [7:0] rt_rdata, ram_lock, q;
  cfg_t cfg;
  offsets_t offsets;
  wire logic [7:0] ram_rdata = ram_cmd.addr ^ 8'h5a;
  int n_errors = 0, cmp_count = 0, cycles = 0;
  row_t rows [13] = '{
    '{8'h30, 8'h00, 8'hff, 8'hff}, '{8'h60, 8'h00, 8'ha5, 8'ha5},
    '{8'h61, 8'h70, 8'hff, 8'hfe}, '{8'h62, 8'h00, 8'h5a, 8'h5a},
    '{8'h63, 8'h72, 8'hff, 8'hfe}, '{8'h70, 8'h08, 8'h3c, 8'h3c},
    '{8'h71, 8'h00, 8'hff, 8'h02}, '{8'h74, 8'h04, 8'hff, 8'h04},
    '{8'h75, 8'h04, 8'h00, 8'h04}, '{8'hf1, 8'h00, 8'hff, 8'h7f},
    '{8'hf2, 8'h00, 8'h55, 8'h55}, '{8'hf3, 8'h00, 8'hff, 8'h7f},
    '{8'h88, 8'h00, 8'hff, 8'h00}};
  logic [7:0] locks [6] = '{8'h00, 8'h80, 8'h40, 8'h20, 8'h10, 8'h08};
  logic [8:0] ops [4] = '{9'h03a, 9'h010, 9'h110, 9'h140};

  rtc_config_and_ram_lock #(.ADDR_WIDTH(10)) dut (
    .clk(clk), .rstn(rstn), .sb_rstn(sb_rstn), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .standby_lock_select(standby_lock_select),
    .unlock_request(unlock_request), .rt_req(rt_req), .ram_rdata(ram_rdata),
    .ram_cmd(ram_cmd), .rt_rdata(rt_rdata), .rt_rvalid(rt_rvalid),
    .cfg(cfg), .offsets(offsets), .ram_lock(ram_lock));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, d, input logic be);
    @(posedge clk);
    address <= {idx, 2'b00};
    read <= !w;
    write <= w;
    writedata <= {24'h0, d};
    byteenable <= be ? 4'hf : 4'he;
    // no cycle count assumed; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 0;
    write <= 0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx, e);
    bus(0, idx, 8'h00, 1);
    chk8(nm, e, q);
  endtask

  // tiny reference of the gate, used only for expectations
  task automatic rt(input logic rd, e, input logic [7:0] a, l, input logic act);
    logic win, lo, ok;
    win = !e && l[7] && a >= 8'h38 && a <= 8'h3f;
    lo = a <= 8'h1f;
    if (rd)
      ok = act && !(win || (e && (l[3] || (l[4] && lo))));
    else
      ok = act && !(l[6] || win || (e && (l[3] || (l[5] && lo))));
    @(posedge clk);
    rt_req <= '{rd: rd, wr: !rd, ext: e, addr: a, wdata: 8'hc3};
    @(posedge clk);
    rt_req <= '0;
    #1;
    chk8("ram_cmd", {6'h0, rd & ok, !rd & ok},
         {6'h0, ram_cmd.re, ram_cmd.we});
    if (rd) begin
      @(posedge clk);
      #1;
      chk8("rt_rvalid", 8'h01, {7'h0, rt_rvalid});
      chk8("rt_rdata", ok ? a ^ 8'h5a : 8'hff, rt_rdata);
    end
  endtask

  task automatic pulse(input logic sb, input logic unlock);
    @(posedge clk);
    if (unlock)
      unlock_request <= 1;
    else if (sb)
      sb_rstn <= 0;
    else
      rstn <= 0;
    repeat (3) @(posedge clk);
    unlock_request <= 0;
    sb_rstn <= 1;
    rstn <= 1;
  endtask

  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("ERROR timeout expected finish seen %0d cycles", cycles);
      summarize();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    sb_rstn <= 1;
    foreach (rows[i]) begin
      rdc("reset value", rows[i].idx, rows[i].rst);
      bus(1, rows[i].idx, rows[i].wd, 1);
      rdc("readback", rows[i].idx, rows[i].exp);
    end
    chk8("cfg active", 8'h01, {7'h0, cfg.active});
    chk8("cfg irq_number", 8'h3c, cfg.irq_number);
    chk8("cfg irq_type", 8'h02, cfg.irq_type);
    chk8("cfg std_base", 8'hfe, cfg.std_base[7:0]);
    chk8("cfg ext_base", 8'h5a, cfg.ext_base[15:8]);
    chk8("offsets month", 8'h55, {1'b0, offsets.month});
    $display("done: register table");
    bus(1, 8'h70, 8'h11, 0);
    rdc("lane off", 8'h70, 8'h3c);
    foreach (locks[i]) begin
      pulse(0, 1);
      bus(1, 8'hf0, locks[i], 1);
      rdc("lock", 8'hf0, locks[i]);
      foreach (ops[j]) begin
        rt(0, ops[j][8], ops[j][7:0], locks[i], 1);
        rt(1, ops[j][8], ops[j][7:0], locks[i], 1);
      end
    end
    $display("done: lock gating");
    pulse(0, 1);
    bus(1, 8'hf0, 8'h80, 1);
    bus(1, 8'hf0, 8'h00, 1);
    rdc("zero write", 8'hf0, 8'h80);
    bus(1, 8'hf0, 8'h47, 1);
    rdc("set write", 8'hf0, 8'hc0);
    chk8("ram_lock pin", 8'hc0, ram_lock);
    $display("done: write one to set");
    standby_lock_select <= 1;
    pulse(0, 0);
    rdc("lock kept", 8'hf0, 8'hc0);
    rdc("offset kept", 8'hf1, 8'h7f);
    rdc("irq reset", 8'h70, 8'h08);
    rdc("active reset", 8'h30, 8'h00);
    pulse(0, 1);
    rt(0, 1, 8'h40, 8'h00, 0);
    rt(1, 0, 8'h10, 8'h00, 0);
    bus(1, 8'hf0, 8'h20, 1);
    standby_lock_select <= 0;
    pulse(0, 0);
    rdc("lock cleared", 8'hf0, 8'h00);
    pulse(1, 0);
    rdc("offset cleared", 8'hf3, 8'h00);
    $display("done: resets");
    summarize();
  end
endmodule
